// File: logic/clock_switch_pll_sequencer.sv
// Clock source switch sequencer with APB registers and PLL settings
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module clock_switch_pll_sequencer
  import clk_switch_pkg::*;
#(
  parameter int SETTLE_TICKS = SETTLE_CYCLES
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              switch_permit_cfg,
  input  wire source_type        boot_source_cfg,
  input  wire logic [1:0]        primary_submode_cfg,
  input  wire logic [3:0]        pll_prescale_cfg,
  input  wire logic              watchdog_enable,
  input  wire osc_status_type    osc_status,
  output osc_enable_type         osc_enable,
  output source_type             sys_source,
  output logic      [3:0]        pll_prescale_div,
  output logic      [3:0]        sys_postscale_div,
  output logic      [23:0]       ref_half_period
);
  switch_state_type     state;
  switch_state_type     next_state;
  source_type           current_source_sel;
  source_type           new_source_sel;
  source_type           next_current;
  source_type           next_new;
  logic                 lock_status;
  logic                 clock_fail_flag;
  logic                 secondary_keepon;
  logic                 switch_request;
  logic                 next_lock;
  logic                 next_fail;
  logic                 next_keepon;
  logic                 next_request;
  logic [TRIM_W-1:0]    trim;
  logic [DIV_W-1:0]     divider;
  logic [1:0]           sys_postscale_sel;
  logic [TRIM_W-1:0]    next_trim;
  logic [DIV_W-1:0]     next_divider;
  logic [1:0]           next_postscale;
  logic [31:0]          next_prdata;
  osc_enable_type       next_enable;
  logic [3:0]           next_prescale_div;
  logic [3:0]           next_postscale_div;
  logic                 access;
  logic                 wr;
  logic                 mapped;
  logic                 ctl_write;
  logic                 high_armed;
  logic                 low_armed;
  logic                 high_write;
  logic                 low_write;
  logic                 switching_on;
  logic                 target_ready;
  logic                 settle_done;
  logic                 start_switch;
  logic                 equal_request;
  logic [15:0]          ctl_value;

  function automatic osc_enable_type needs(input source_type src);
    osc_enable_type e;
    e              = '0;
    e.fast_rc      = (src == SRC_FAST_RC) || (src == SRC_FAST_RC_PLL) || (src == SRC_FRAC_DIV);
    e.primary      = (src == SRC_PRIMARY) || (src == SRC_PRIMARY_PLL);
    e.pll          = (src == SRC_FAST_RC_PLL) || (src == SRC_PRIMARY_PLL);
    e.secondary    = (src == SRC_SECONDARY);
    e.low_power_rc = (src == SRC_LOW_POWER_RC);
    return e;
  endfunction : needs

  // APB decode, zero wait states
  assign access    = psel && penable;
  assign wr        = access && pwrite;
  assign mapped    = (paddr == OSC_CONTROL_OFF) || (paddr == POSTSCALE_OFF) ||
                     (paddr == TRIM_OFF) || (paddr == DIVIDER_OFF);
  assign pready    = 1'b1;
  assign pslverr   = access && !mapped;
  assign ctl_write = wr && (paddr == OSC_CONTROL_OFF);

  unlock_keys #(
    .FIRST_KEY  (HIGH_KEY_FIRST),
    .SECOND_KEY (HIGH_KEY_SECOND)
  ) high_keys (
    .pclk       (pclk),
    .presetn    (presetn),
    .access     (access),
    .lane_write (ctl_write && pstrb[1]),
    .lane_data  (pwdata[15:8]),
    .armed      (high_armed)
  );

  unlock_keys #(
    .FIRST_KEY  (LOW_KEY_FIRST),
    .SECOND_KEY (LOW_KEY_SECOND)
  ) low_keys (
    .pclk       (pclk),
    .presetn    (presetn),
    .access     (access),
    .lane_write (ctl_write && pstrb[0]),
    .lane_data  (pwdata[7:0]),
    .armed      (low_armed)
  );

  // high byte written only right after its keys
  assign high_write = ctl_write && pstrb[1] && high_armed;
  // low byte written only right after its keys
  assign low_write  = ctl_write && pstrb[0] && low_armed;

  assign switching_on = !switch_permit_cfg;

  // crystal start-up timer and PLL lock gate readiness
  assign target_ready =
    (!needs(new_source_sel).primary || primary_submode_cfg == SUB_EXT_CLOCK ||
     osc_status.startup_done) &&
    (!needs(new_source_sel).pll || osc_status.pll_locked);

  assign equal_request = (state == ST_IDLE) && switch_request &&
                         (new_source_sel == current_source_sel);
  assign start_switch  = (state == ST_IDLE) && switch_request && switching_on &&
                         (new_source_sel != current_source_sel);

  // ten ticks of the new clock
  settle_counter #(
    .WIDTH  (4),
    .TARGET (SETTLE_TICKS)
  ) settle (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (state != ST_SETTLE),
    .tick    (osc_status.new_clock_tick),
    .done    (settle_done)
  );

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (start_switch) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (target_ready) begin
          next_state = ST_SETTLE;
        end
      end
      ST_SETTLE: begin
        if (settle_done) begin
          next_state = ST_CHANGE;
        end
      end
      ST_CHANGE: begin
        next_state = ST_IDLE;
      end
    endcase
    // Software withdrawal or loss of permit abandons the switch
    if (!switch_request || !switching_on) begin
      next_state = ST_IDLE;
    end
  end

  always_comb begin
    next_current = current_source_sel;
    next_new     = new_source_sel;
    next_lock    = osc_enable.pll && osc_status.pll_locked;
    next_fail    = clock_fail_flag;
    next_keepon  = secondary_keepon;
    next_request = switch_request;
    if (high_write) begin
      next_new = pwdata[NEW_LSB +: 3];
    end
    if (low_write) begin
      next_keepon = pwdata[KEEPON_BIT];
      next_fail   = clock_fail_flag && pwdata[FAIL_BIT];
    end
    if (equal_request) begin
      next_request = 1'b0;
    end
    // changeover commits and clears the request
    if (state == ST_CHANGE) begin
      next_current = new_source_sel;
      next_request = 1'b0;
    end
    if (low_write) begin
      next_request = pwdata[REQ_BIT] || (switch_request && next_request);
      if (!pwdata[REQ_BIT]) begin
        next_request = 1'b0;
      end
    end
    // valid start clears lock and fail
    if (start_switch) begin
      next_lock = 1'b0;
      next_fail = 1'b0;
    end
    // fail-safe monitor only with switching on; set wins
    if (switching_on && osc_status.clock_failed) begin
      next_fail = 1'b1;
    end
    // current follows boot config; request held low
    if (!switching_on) begin
      next_current = boot_source_cfg;
      next_request = 1'b0;
    end
  end

  // old source dropped, keep LOW_POWER_RC_OSC with watchdog or switching on, and kept-on secondary
  always_comb begin
    next_enable = needs(current_source_sel);
    if (state != ST_IDLE) begin
      next_enable = next_enable | needs(new_source_sel);
    end
    if (state == ST_CHANGE) begin
      next_enable = needs(new_source_sel);
    end
    next_enable.low_power_rc = next_enable.low_power_rc || watchdog_enable || switching_on;
    next_enable.secondary    = next_enable.secondary || secondary_keepon;
  end

  always_comb begin
    next_trim      = trim;
    next_divider   = divider;
    next_postscale = sys_postscale_sel;
    if (wr && paddr == TRIM_OFF) begin
      if (pstrb[0]) begin
        next_trim[0] = pwdata[TRIM_LSB];
      end
      if (pstrb[1]) begin
        next_trim[TRIM_W-1:1] = pwdata[15:8];
      end
    end
    if (wr && paddr == DIVIDER_OFF) begin
      if (pstrb[0]) begin
        next_divider[7:0] = pwdata[7:0];
      end
      if (pstrb[1]) begin
        next_divider[DIV_W-1:8] = pwdata[14:8];
      end
    end
    if (wr && paddr == POSTSCALE_OFF && pstrb[0]) begin
      next_postscale = pwdata[POST_LSB +: 2];
    end
  end

  always_comb begin
    next_prescale_div = RATIO_ONE;
    if (!pll_prescale_cfg[3]) begin
      next_prescale_div = PRESCALE_RATIO[pll_prescale_cfg[2:0]];
    end
    // postscale divide by 1, 2, 4, 8
    next_postscale_div = RATIO_ONE << sys_postscale_sel;
  end

  // request bit reads zero when switching is off
  assign ctl_value = {1'b0, current_source_sel, 1'b0, new_source_sel, 2'b00,
                      lock_status, 1'b0, clock_fail_flag, 1'b0, secondary_keepon,
                      switch_request && switching_on};

  always_comb begin
    next_prdata = prdata;
    if (psel && !penable) begin
      next_prdata = 32'h0000_0000;
      unique case (paddr)
        OSC_CONTROL_OFF: next_prdata[15:0] = ctl_value;
        POSTSCALE_OFF:   next_prdata[POST_LSB +: 2] = sys_postscale_sel;
        TRIM_OFF:        next_prdata[TRIM_LSB +: TRIM_W] = trim;
        DIVIDER_OFF:     next_prdata[DIV_W-1:0] = divider;
        default:         next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // system source changes at changeover, or follows boot config when switching is off, never stopped
  assign sys_source = current_source_sel;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state              <= ST_IDLE;
      current_source_sel <= SRC_FAST_RC;
      new_source_sel     <= SRC_FAST_RC;
      lock_status        <= 1'b0;
      clock_fail_flag    <= 1'b0;
      secondary_keepon   <= 1'b0;
      switch_request     <= 1'b0;
      trim               <= TRIM_RESET;
      divider            <= DIV_RESET;
      sys_postscale_sel  <= POST_RESET;
      prdata             <= 32'h0000_0000;
      osc_enable         <= '0;
      pll_prescale_div   <= RATIO_ONE;
      sys_postscale_div  <= RATIO_ONE;
      ref_half_period    <= 24'h000000;
    end else begin
      state              <= next_state;
      current_source_sel <= next_current;
      new_source_sel     <= next_new;
      lock_status        <= next_lock;
      clock_fail_flag    <= next_fail;
      secondary_keepon   <= next_keepon;
      switch_request     <= next_request;
      trim               <= next_trim;
      divider            <= next_divider;
      sys_postscale_sel  <= next_postscale;
      prdata             <= next_prdata;
      osc_enable         <= next_enable;
      pll_prescale_div   <= next_prescale_div;
      sys_postscale_div  <= next_postscale_div;
      ref_half_period    <= {divider, trim};
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_settle_entry;
    state == ST_WAIT && target_ready && switch_request && switching_on;
  endsequence

  a_trim_fraction: assert property (
    wr && paddr == TRIM_OFF && pstrb[1:0] == 2'h3 |=> ##1
      ref_half_period[TRIM_W-1:0] == $past(pwdata[15:7], 2))
    else $error("trim not reflected in half period");
  a_request_blocked: assert property (
    switch_permit_cfg && $past(switch_permit_cfg) |-> !switch_request)
    else $error("request set while switching disabled");
  a_boot_source: assert property (
    switch_permit_cfg && $past(switch_permit_cfg) && $past(presetn) |->
      sys_source == $past(boot_source_cfg))
    else $error("current source not from boot config");
  a_equal_abort: assert property (
    equal_request && !low_write |=> !switch_request && state == ST_IDLE)
    else $error("redundant request not aborted");
  a_start_clears: assert property (
    start_switch && !osc_status.clock_failed |=> !lock_status && !clock_fail_flag)
    else $error("lock or fail not cleared at start");
  a_wait_ready: assert property (
    state == ST_WAIT && !target_ready |=> state != ST_SETTLE)
    else $error("left wait before source ready");
  a_settle_ten: assert property (
    s_settle_entry |=> (state != ST_CHANGE)[*8])
    else $error("changeover before ten new-clock cycles");
  a_change_commit: assert property (
    state == ST_CHANGE && !low_write && switching_on |=>
      sys_source == $past(new_source_sel) && !switch_request && state == ST_IDLE)
    else $error("changeover did not commit");
  a_key_needed: assert property (
    ctl_write && pstrb[1] && !high_armed |=> new_source_sel == $past(new_source_sel))
    else $error("new source written without unlock");
  a_lock_off: assert property (
    !osc_enable.pll |=> !lock_status)
    else $error("lock reported with PLL off");
  a_postscale: assert property (
    $stable(sys_postscale_sel) [*2] |-> sys_postscale_div == (RATIO_ONE << sys_postscale_sel))
    else $error("postscale divide wrong");
endmodule : clock_switch_pll_sequencer
`default_nettype wire

// File: common/clk_switch_pkg.sv
// Shared constants and types for the clock switch sequencer
package clk_switch_pkg;

  localparam int ADDR_W = 12;

  localparam logic [ADDR_W-1:0] OSC_CONTROL_OFF = 12'h000;
  localparam logic [ADDR_W-1:0] POSTSCALE_OFF   = 12'h004;
  localparam logic [ADDR_W-1:0] TRIM_OFF        = 12'h008;
  localparam logic [ADDR_W-1:0] DIVIDER_OFF     = 12'h00c;

  localparam logic [7:0] HIGH_KEY_FIRST  = 8'h78;
  localparam logic [7:0] HIGH_KEY_SECOND = 8'h9a;
  localparam logic [7:0] LOW_KEY_FIRST   = 8'h46;
  localparam logic [7:0] LOW_KEY_SECOND  = 8'h57;

  localparam int CUR_LSB    = 12;
  localparam int NEW_LSB    = 8;
  localparam int LOCK_BIT   = 5;
  localparam int FAIL_BIT   = 3;
  localparam int KEEPON_BIT = 1;
  localparam int REQ_BIT    = 0;
  localparam int TRIM_LSB   = 7;
  localparam int TRIM_W     = 9;
  localparam int POST_LSB   = 6;
  localparam int DIV_W      = 15;

  localparam logic [DIV_W-1:0]  DIV_RESET  = 15'h0001;
  localparam logic [TRIM_W-1:0] TRIM_RESET = 9'h000;
  localparam logic [1:0]        POST_RESET = 2'h0;

  localparam int SETTLE_CYCLES = 10;

  localparam int PLL_REF_MHZ   = 4;
  localparam int PLL_VCO_MHZ   = 96;
  localparam int PLL_FIXED_DIV = 3;
  localparam logic [3:0] PRESCALE_RATIO [0:7] =
    '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'hc};
  localparam logic [3:0] RATIO_ONE = 4'h1;

  typedef logic [2:0] source_type;
  localparam source_type SRC_FAST_RC       = 3'h0;
  localparam source_type SRC_FAST_RC_PLL   = 3'h1;
  localparam source_type SRC_PRIMARY       = 3'h2;
  localparam source_type SRC_PRIMARY_PLL   = 3'h3;
  localparam source_type SRC_SECONDARY     = 3'h4;
  localparam source_type SRC_LOW_POWER_RC  = 3'h5;
  localparam source_type SRC_FRAC_DIV      = 3'h7;

  localparam logic [1:0] SUB_EXT_CLOCK = 2'h0;

  typedef struct packed {
    logic fast_rc;
    logic primary;
    logic secondary;
    logic low_power_rc;
    logic pll;
  } osc_enable_type;

  typedef struct packed {
    logic startup_done;
    logic pll_locked;
    logic new_clock_tick;
    logic clock_failed;
  } osc_status_type;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0001,
    ST_WAIT   = 4'b0010,
    ST_SETTLE = 4'b0100,
    ST_CHANGE = 4'b1000
  } switch_state_type;

endpackage : clk_switch_pkg

// File: logic/unlock_keys.sv
// Two-key unlock that arms one following byte write
`timescale 1ns/1ps
`default_nettype none
module unlock_keys #(
  parameter logic [7:0] FIRST_KEY  = 8'h00,
  parameter logic [7:0] SECOND_KEY = 8'h00
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       access,
  input  wire logic       lane_write,
  input  wire logic [7:0] lane_data,
  output logic            armed
);
  logic got_first;
  logic next_got_first;
  logic next_armed;

  always_comb begin
    next_got_first = got_first;
    next_armed     = armed;
    if (access) begin
      next_got_first = 1'b0;
      next_armed     = 1'b0;
      if (lane_write && !armed) begin
        if (!got_first && lane_data == FIRST_KEY) begin
          next_got_first = 1'b1;
        end else if (got_first && lane_data == SECOND_KEY) begin
          next_armed = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      got_first <= 1'b0;
      armed     <= 1'b0;
    end else begin
      got_first <= next_got_first;
      armed     <= next_armed;
    end
  end
endmodule : unlock_keys
`default_nettype wire

// File: logic/settle_counter.sv
// Counts new-clock ticks up to a target
`timescale 1ns/1ps
`default_nettype none
module settle_counter #(
  parameter int WIDTH  = 4,
  parameter int TARGET = 10
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic clear,
  input  wire logic tick,
  output logic      done
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;

  assign done = (count == TARGET[WIDTH-1:0]);

  always_comb begin
    next_count = count;
    if (clear) begin
      next_count = '0;
    end else if (tick && !done) begin
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule : settle_counter
`default_nettype wire

// File: bench/osc_model.sv
// Oscillator and PLL behaviour seen by the switch sequencer
`timescale 1ns/1ps
`default_nettype none
module osc_model
  import clk_switch_pkg::*;
#(
  parameter int START_CYC = 20,
  parameter int LOCK_CYC  = 30
) (
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire osc_enable_type osc_enable,
  input  wire logic           fail_in,
  output osc_status_type      osc_status
);
  logic [7:0] start_cnt;
  logic [7:0] next_start_cnt;
  logic [7:0] lock_cnt;
  logic [7:0] next_lock_cnt;
  logic [1:0] tick_cnt;
  logic [1:0] next_tick_cnt;
  always_comb begin
    next_start_cnt = osc_enable.primary ? start_cnt + 8'(start_cnt < 8'(START_CYC)) : 8'h00;
    next_lock_cnt  = osc_enable.pll ? lock_cnt + 8'(lock_cnt < 8'(LOCK_CYC)) : 8'h00;
    next_tick_cnt  = tick_cnt + 2'h1;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_cnt <= 8'h00;
      lock_cnt  <= 8'h00;
      tick_cnt  <= 2'h0;
    end else begin
      start_cnt <= next_start_cnt;
      lock_cnt  <= next_lock_cnt;
      tick_cnt  <= next_tick_cnt;
    end
  end
  // new clock tick every fourth cycle
  assign osc_status = {start_cnt == 8'(START_CYC), lock_cnt == 8'(LOCK_CYC), tick_cnt == 2'h0,
                       fail_in};
endmodule : osc_model
`default_nettype wire

// File: bench/clock_switch_pll_sequencer_tb.sv
// Register-level test of the clock switch sequencer
`timescale 1ns/1ps
`default_nettype none
module clock_switch_pll_sequencer_tb;
  import clk_switch_pkg::*;
  logic           pclk = 1'b0;
  logic           presetn, psel, penable, pwrite, pready, pslverr, err;
  logic           permit, wdog, fail_in;
  logic [11:0]    paddr;
  logic [31:0]    pwdata, prdata, r;
  logic [3:0]     pstrb, prescale, pre_div, post_div, s_pre, s_post;
  logic [1:0]     submode;
  source_type     boot, sys_source, s_src;
  osc_status_type osc_status;
  osc_enable_type osc_enable, s_en;
  logic [23:0]    ref_hp, s_hp;
  logic [3:0]     ratio [0:8] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h8, 4'hc, 4'h1};
  int             error_cnt = 0;
  int             checked = 0;

  always #2.5 pclk = ~pclk;

  clock_switch_pll_sequencer #(.SETTLE_TICKS(10)) dut_u (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .switch_permit_cfg(permit), .boot_source_cfg(boot), .primary_submode_cfg(submode),
    .pll_prescale_cfg(prescale), .watchdog_enable(wdog), .osc_status(osc_status),
    .osc_enable(osc_enable), .sys_source(sys_source), .pll_prescale_div(pre_div),
    .sys_postscale_div(post_div), .ref_half_period(ref_hp));

  osc_model osc_u (.pclk(pclk), .presetn(presetn), .osc_enable(osc_enable),
    .fail_in(fail_in), .osc_status(osc_status));

  task automatic report_and_stop();
    if (error_cnt == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n >= 20) begin
      chk(0, 1, "no ready");
      report_and_stop();
    end
  endtask : xfer

  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    s_src = sys_source;
    s_en = osc_enable;
    s_pre = pre_div;
    s_post = post_div;
    s_hp = ref_hp;
    @(posedge pclk);
  endtask : idle

  task automatic sw(input source_type src, input logic [31:0] exp, input logic [31:0] mask);
    int n;
    n = 0;
    xfer(1'b1, 12'h000, 32'h7800, 4'h2);
    xfer(1'b1, 12'h000, 32'h9a00, 4'h2);
    xfer(1'b1, 12'h000, {21'h0, src, 8'h00}, 4'h2);
    xfer(1'b1, 12'h000, 32'h46, 4'h1);
    xfer(1'b1, 12'h000, 32'h57, 4'h1);
    xfer(1'b1, 12'h000, 32'h09, 4'h1);
    do begin
      xfer(1'b0, 12'h000, 32'h0, 4'h0);
      n++;
    end while (r[0] !== 1'b0 && n < 300);
    idle();
    if (n >= 300) begin
      chk(0, 1, "switch hung");
      report_and_stop();
    end
    chk(r & mask, exp, "control after switch");
  endtask : sw

  initial begin
    {presetn, psel, penable, pwrite, err, permit, wdog, fail_in} = '0;
    {paddr, pwdata, pstrb, prescale, boot} = '0;
    submode = 2'h1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, 12'(4 * i), 32'h0, 4'h0);
      chk(r, (i == 3) ? 32'h1 : 32'h0, "reset value");
    end
    xfer(1'b0, 12'h010, 32'h0, 4'h0);
    chk({31'h0, err}, 32'h1, "unmapped error");
    xfer(1'b1, 12'h000, 32'h7800, 4'h2);
    xfer(1'b0, 12'h000, 32'h0, 4'h0);
    xfer(1'b1, 12'h000, 32'h9a00, 4'h2);
    xfer(1'b1, 12'h000, 32'h0200, 4'h2);
    xfer(1'b0, 12'h000, 32'h0, 4'h0);
    chk(r, 32'h0, "broken unlock");
    idle();
    chk(s_hp, 24'h000200, "half period");
    chk(s_en, 5'b10010, "reset sources");
    fail_in <= 1'b1;
    @(posedge pclk);
    fail_in <= 1'b0;
    xfer(1'b0, 12'h000, 32'h0, 4'h0);
    chk(r, 32'h8, "fail flag");
    sw(SRC_PRIMARY, 32'h2200, 32'hffffffff);
    chk(s_src, SRC_PRIMARY, "source out");
    chk(s_en, 5'b01010, "old source off");
    sw(SRC_PRIMARY, 32'h2200, 32'hffffffff);
    sw(SRC_PRIMARY_PLL, 32'h3320, 32'hffffffff);
    chk(s_en, 5'b01011, "pll on");
    sw(SRC_FAST_RC, 32'h0000, 32'hffffffff);
    sw(SRC_FAST_RC_PLL, 32'h1120, 32'hffffffff);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 12'h004, 32'(i << 6), 4'h1);
      xfer(1'b0, 12'h004, 32'h0, 4'h0);
      idle();
      chk(r, 32'(i << 6), "postscale read");
      chk(s_post, 32'(1 << i), "postscale");
    end
    for (int i = 0; i < 9; i++) begin
      prescale <= 4'(i);
      idle();
      chk(s_pre, ratio[i], "prescale");
    end
    xfer(1'b1, 12'h00c, 32'h3, 4'h3);
    xfer(1'b1, 12'h008, 32'hff80, 4'h3);
    xfer(1'b0, 12'h008, 32'h0, 4'h0);
    idle();
    chk(r, 32'hff80, "trim read");
    chk(s_hp, 24'h0007ff, "trimmed half period");
    permit <= 1'b1;
    boot <= SRC_LOW_POWER_RC;
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    idle();
    chk(s_src, SRC_LOW_POWER_RC, "boot source");
    sw(SRC_PRIMARY, 32'h5000, 32'h7001);
    chk(s_src, SRC_LOW_POWER_RC, "no switch");
    report_and_stop();
  end
endmodule : clock_switch_pll_sequencer_tb
`default_nettype wire
